// ===== verilog/cell_array_pkg.sv
package cell_array_pkg;

   // ****************************************************************
   // array geometry
   // ****************************************************************
   localparam int NUM_MC     = 8;            // output macrocells
   localparam int NUM_IN     = 8;            // dedicated input pins
   localparam int PT_PER_MC  = 8;            // product terms per macrocell
   localparam int ARRAY_SIGS = 16;           // signals entering the AND array
   localparam int ARRAY_COLS = 2 * ARRAY_SIGS;
   localparam int NUM_ROWS   = NUM_MC * PT_PER_MC;
   localparam int SIG_BITS   = 64;           // user signature store
   localparam int ROW_SEL_W  = 6;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_MODE     = 8'h04;
   localparam logic [7:0] ADDR_MCCFG    = 8'h08;
   localparam logic [7:0] ADDR_ROW_SEL  = 8'h0c;
   localparam logic [7:0] ADDR_ROW_DATA = 8'h10;
   localparam logic [7:0] ADDR_PRELOAD  = 8'h14;
   localparam logic [7:0] ADDR_STATUS   = 8'h18;
   localparam logic [7:0] ADDR_SIG_LO   = 8'h1c;
   localparam logic [7:0] ADDR_SIG_HI   = 8'h20;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int CTRL_PROG_BIT     = 0;     // configuration writable
   localparam int CTRL_SECURE_BIT   = 1;     // write 1 to blow protection
   localparam int STAT_SECURE_BIT   = 8;
   localparam int STAT_REFUSED_BIT  = 9;     // sticky, write 1 to clear
   localparam int STAT_PROG_BIT     = 10;
   localparam int MCCFG_FIELD_W     = 3;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [7:0]  RST_REGS    = 8'h00;

   // ****************************************************************
   // modes and per-macrocell configuration
   // ****************************************************************
   typedef enum logic [1:0] {
      MODE_REGISTERED,
      MODE_COMPLEX,
      MODE_SIMPLE
   } macrocell_architecture_mode_t;

   typedef enum logic [1:0] {
      FN_REGISTERED,
      FN_COMB_IO,
      FN_COMB_OUT,
      FN_INPUT
   } mc_func_t;

   typedef struct packed {
      mc_func_t func;
      logic     invert;
   } mc_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic d;
   } mc_drive_t;

   // true and complement column for each array signal
   function automatic logic [ARRAY_COLS-1:0] literals(input logic [ARRAY_SIGS-1:0] s);
      logic [ARRAY_COLS-1:0] v;
      v = '0;
      for (int k = 0; k < ARRAY_SIGS; k++) begin
         v[2*k]   = s[k];
         v[2*k+1] = ~s[k];
      end
      return v;
   endfunction : literals

endpackage : cell_array_pkg

// ===== verilog/product_terms.sv
`timescale 1ns/100ps
module product_terms
   import cell_array_pkg::*;
#(
   parameter int PT   = PT_PER_MC,
   parameter int COLS = ARRAY_COLS
) (
   input  wire logic [COLS-1:0] rows [PT],
   input  wire logic [COLS-1:0] lits,
   output logic      [PT-1:0]   pt,
   output logic      [PT-1:0]   used
);

   // ****************************************************************
   // wired AND of every connected literal
   // ****************************************************************
   // an empty row is flagged unused so the sum can drop it
   always_comb begin
      for (int k = 0; k < PT; k++) begin
         used[k] = |rows[k];
         pt[k]   = used[k] & (&(~rows[k] | lits));
      end
   end

endmodule : product_terms

// ===== verilog/macrocell_output.sv
`timescale 1ns/100ps
module macrocell_output
   import cell_array_pkg::*;
(
   input  wire macrocell_architecture_mode_t mode,
   input  wire mc_cfg_t                      cfg,
   input  wire logic [PT_PER_MC-1:0]         pt,
   input  wire logic [PT_PER_MC-1:0]         used,
   input  wire logic                         q,
   input  wire logic                         oe_lvl_n,
   input  wire logic                         outer,
   input  wire logic                         centre,
   output mc_drive_t                         drv
);

   logic sum7;
   logic sum8;
   logic oe_term;

   // ****************************************************************
   // sum terms and per-macrocell enable
   // ****************************************************************
   // term 0 doubles as the enable term; an empty one means always on
   assign sum8    = |pt;
   assign sum7    = |pt[PT_PER_MC-1:1];
   assign oe_term = used[0] ? pt[0] : 1'b1;

   always_comb begin
      drv.d   = sum8 ^ cfg.invert;
      drv.out = 1'b0;
      drv.oe  = 1'b0;
      unique case (mode)
         MODE_REGISTERED: begin
            if (cfg.func == FN_REGISTERED) begin
               drv.out = ~q;
               drv.oe  = ~oe_lvl_n;
            end else if (cfg.func == FN_INPUT) begin
               drv.oe  = 1'b0;
            end else begin
               drv.out = sum7 ^ cfg.invert;
               drv.oe  = oe_term;
            end
         end
         MODE_COMPLEX: begin
            drv.out = sum7 ^ cfg.invert;
            drv.oe  = (cfg.func == FN_INPUT && !outer) ? 1'b0 : oe_term;
         end
         MODE_SIMPLE: begin
            drv.out = sum8 ^ cfg.invert;
            drv.oe  = centre | (cfg.func != FN_INPUT);
         end
         default: begin
            drv.out = 1'b0;
            drv.oe  = 1'b0;
         end
      endcase
   end

endmodule : macrocell_output

// ===== verilog/configurable_macrocell_array.sv
// What this block does
// - secured device refuses verify and preload
// - 64-bit signature always readable
// - undriven pins read as high
// - macrocell: registered, bidirectional, output, or input
// - one of three architecture modes
// - registered mode: clock and enable pins dedicated
// - registered cell: eight terms, common enable
// - combinatorial cell: seven terms plus enable term
// - input cell drives its pin only as complex outer or simple centre cell
// - complex mode: seven terms plus enable
// - complex: clock/enable pins take outer feedback
// - complex: outer cells output only, inner bidirectional
// - simple mode: eight terms, pins are inputs
// - simple: centre cells always-on, no feedback
// - simple: feedback routed via adjacent path
// - registers clear low, registered pins high
// - preload forces register values
`timescale 1ns/100ps
module configurable_macrocell_array
   import cell_array_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [NUM_IN-1:0] in_pin,
   input  wire logic [NUM_IN-1:0] in_pin_driven,
   input  wire logic              clk_pin,
   input  wire logic              clk_pin_driven,
   input  wire logic              oe_pin_n,
   input  wire logic              oe_pin_driven,
   input  wire logic [NUM_MC-1:0] io_in,
   input  wire logic [NUM_MC-1:0] io_driven,
   output logic      [NUM_MC-1:0] io_out,
   output logic      [NUM_MC-1:0] io_oe
);

   // ****************************************************************
   // configuration state
   // ****************************************************************
   logic                          prog_r;
   logic                          secure_r;
   logic                          refused_r;
   macrocell_architecture_mode_t  mode_r;
   mc_cfg_t                       cfg_r [NUM_MC];
   logic [ROW_SEL_W-1:0]          row_sel_r;
   logic [ARRAY_COLS-1:0]         rows_r [NUM_ROWS];
   logic [SIG_BITS-1:0]           sig_r;
   logic [NUM_MC-1:0]             q_r;
   logic                          clk_prev_r;

   // ****************************************************************
   // pin levels, array inputs
   // ****************************************************************
   logic [NUM_IN-1:0]             in_lvl;
   logic                          clk_lvl;
   logic                          oe_lvl_n;
   logic [NUM_MC-1:0]             io_lvl;
   logic [NUM_MC-1:0]             fb;
   logic [ARRAY_COLS-1:0]         lits;
   logic                          clk_rise;

   // weak pull-up: an undriven pin is seen high, a driver overrides it
   assign in_lvl   = in_pin | ~in_pin_driven;
   assign clk_lvl  = clk_pin | ~clk_pin_driven;
   assign oe_lvl_n = oe_pin_n | ~oe_pin_driven;
   assign io_lvl   = io_in | ~(io_driven | io_oe);
   assign clk_rise = clk_lvl & ~clk_prev_r;

   // feedback routing depends on the architecture mode
   always_comb begin
      fb = '0;
      unique case (mode_r)
         MODE_REGISTERED: begin
            // clock and enable pins never enter the array here
            for (int m = 0; m < NUM_MC; m++) begin
               fb[m] = (cfg_r[m].func == FN_REGISTERED) ? q_r[m] : io_lvl[m];
            end
         end
         MODE_COMPLEX: begin
            fb    = io_lvl;
            fb[0] = clk_lvl;
            fb[NUM_MC-1] = ~oe_lvl_n;
         end
         MODE_SIMPLE: begin
            // outer half shifts one place inward; centre cells drop out
            fb[0] = clk_lvl;
            for (int m = 1; m < NUM_MC/2; m++) begin
               fb[m] = io_lvl[m-1];
            end
            for (int m = NUM_MC/2; m < NUM_MC-1; m++) begin
               fb[m] = io_lvl[m+1];
            end
            fb[NUM_MC-1] = ~oe_lvl_n;
         end
         default: begin
            fb = '0;
         end
      endcase
   end

   assign lits = literals({fb, in_lvl});

   // ****************************************************************
   // AND array and macrocells
   // ****************************************************************
   logic [PT_PER_MC-1:0] pt   [NUM_MC];
   logic [PT_PER_MC-1:0] used [NUM_MC];
   mc_drive_t            drv  [NUM_MC];

   for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
      product_terms #(
         .PT   (PT_PER_MC),
         .COLS (ARRAY_COLS)
      ) u_terms (
         .rows (rows_r[m*PT_PER_MC +: PT_PER_MC]),
         .lits (lits),
         .pt   (pt[m]),
         .used (used[m])
      );

      macrocell_output u_cell (
         .mode     (mode_r),
         .cfg      (cfg_r[m]),
         .pt       (pt[m]),
         .used     (used[m]),
         .q        (q_r[m]),
         .oe_lvl_n (oe_lvl_n),
         .outer    (m == 0 || m == NUM_MC-1),
         .centre   (m == NUM_MC/2-1 || m == NUM_MC/2),
         .drv      (drv[m])
      );
   end

   // ****************************************************************
   // APB slave
   // ****************************************************************
   logic        setup;
   logic        access;
   logic        wr;
   logic [31:0] rd_data;
   logic        rd_err;

   assign setup  = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr     = access & pwrite;

   function automatic logic known(input logic [7:0] a);
      return a == ADDR_CTRL || a == ADDR_MODE || a == ADDR_MCCFG || a == ADDR_ROW_SEL
          || a == ADDR_ROW_DATA || a == ADDR_PRELOAD || a == ADDR_STATUS
          || a == ADDR_SIG_LO || a == ADDR_SIG_HI;
   endfunction : known

   // refusal decided in setup so the error flag lines up with pready
   always_comb begin
      rd_data = RST_ZERO;
      rd_err  = ~known(paddr);
      unique case (paddr)
         ADDR_CTRL:     rd_data[CTRL_PROG_BIT] = prog_r;
         ADDR_MODE:     rd_data[1:0] = mode_r;
         ADDR_MCCFG: begin
            for (int m = 0; m < NUM_MC; m++) begin
               rd_data[m*MCCFG_FIELD_W +: MCCFG_FIELD_W] = cfg_r[m];
            end
         end
         ADDR_ROW_SEL:  rd_data[ROW_SEL_W-1:0] = row_sel_r;
         ADDR_ROW_DATA: begin
            rd_data = secure_r ? RST_ZERO : rows_r[row_sel_r];
            rd_err  = secure_r & ~pwrite;
            if (pwrite && (!prog_r || secure_r)) begin
               rd_err = 1'b1;
            end
         end
         ADDR_PRELOAD:  rd_err = pwrite & secure_r;
         ADDR_STATUS: begin
            rd_data[NUM_MC-1:0]       = q_r;
            rd_data[STAT_SECURE_BIT]  = secure_r;
            rd_data[STAT_REFUSED_BIT] = refused_r;
            rd_data[STAT_PROG_BIT]    = prog_r;
         end
         ADDR_SIG_LO:   rd_data = sig_r[31:0];
         ADDR_SIG_HI:   rd_data = sig_r[63:32];
         default:       rd_data = RST_ZERO;
      endcase
      if (pwrite && !prog_r && (paddr == ADDR_MODE || paddr == ADDR_MCCFG
                                || paddr == ADDR_SIG_LO || paddr == ADDR_SIG_HI)) begin
         rd_err = 1'b1;
      end
   end

   // zero wait states: answer prepared during the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= RST_ZERO;
      end else begin
         pready  <= setup;
         pslverr <= setup & rd_err;
         prdata  <= (setup && !pwrite) ? rd_data : RST_ZERO;
      end
   end

   // ****************************************************************
   // control, protection and refusal flag
   // ****************************************************************
   logic refuse_evt;

   assign refuse_evt = access & secure_r
                     & ((paddr == ADDR_ROW_DATA) | (wr & (paddr == ADDR_PRELOAD)));

   // protection only sets; nothing but a full reset clears it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_r   <= 1'b0;
         secure_r <= 1'b0;
      end else if (wr && paddr == ADDR_CTRL) begin
         prog_r   <= pwdata[CTRL_PROG_BIT];
         secure_r <= secure_r | pwdata[CTRL_SECURE_BIT];
      end
   end

   // a refusal in the clearing cycle still sets the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refused_r <= 1'b0;
      end else if (refuse_evt) begin
         refused_r <= 1'b1;
      end else if (wr && paddr == ADDR_STATUS && pwdata[STAT_REFUSED_BIT]) begin
         refused_r <= 1'b0;
      end
   end

   // ****************************************************************
   // nonvolatile configuration image
   // ****************************************************************
   // only accepted in programming state, so logic never sees a half-change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_REGISTERED;
         for (int m = 0; m < NUM_MC; m++) begin
            cfg_r[m] <= '{func: FN_INPUT, invert: 1'b0};
         end
      end else if (wr && prog_r) begin
         if (paddr == ADDR_MODE && pwdata[1:0] != 2'h3) begin
            mode_r <= macrocell_architecture_mode_t'(pwdata[1:0]);
         end
         if (paddr == ADDR_MCCFG) begin
            for (int m = 0; m < NUM_MC; m++) begin
               cfg_r[m] <= mc_cfg_t'(pwdata[m*MCCFG_FIELD_W +: MCCFG_FIELD_W]);
            end
         end
      end
   end

   // row pointer steps after each data access for burst loading
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_sel_r <= '0;
      end else if (wr && paddr == ADDR_ROW_SEL) begin
         row_sel_r <= pwdata[ROW_SEL_W-1:0];
      end else if (access && paddr == ADDR_ROW_DATA) begin
         row_sel_r <= row_sel_r + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int r = 0; r < NUM_ROWS; r++) begin
            rows_r[r] <= '0;
         end
      end else if (wr && paddr == ADDR_ROW_DATA && prog_r && !secure_r) begin
         rows_r[row_sel_r] <= pwdata;
      end
   end

   // signature stays writable in programming state, secured or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_r <= '0;
      end else if (wr && prog_r) begin
         if (paddr == ADDR_SIG_LO) begin
            sig_r[31:0] <= pwdata;
         end
         if (paddr == ADDR_SIG_HI) begin
            sig_r[63:32] <= pwdata;
         end
      end
   end

   // ****************************************************************
   // macrocell registers and pin drivers
   // ****************************************************************
   // starts high like the pulled-up idle pin, so reset brings no false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_r <= 1'b1;
      end else begin
         clk_prev_r <= clk_lvl;
      end
   end

   // preload beats a coincident clock edge so test state is exact
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_r <= RST_REGS;
      end else if (wr && paddr == ADDR_PRELOAD) begin
         if (!secure_r) begin
            q_r <= pwdata[NUM_MC-1:0];
         end
      end else if (clk_rise && !prog_r && mode_r == MODE_REGISTERED) begin
         for (int m = 0; m < NUM_MC; m++) begin
            if (cfg_r[m].func == FN_REGISTERED) begin
               q_r[m] <= drv[m].d;
            end
         end
      end
   end

   // pins float while the image is being reprogrammed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_out <= '0;
         io_oe  <= '0;
      end else begin
         for (int m = 0; m < NUM_MC; m++) begin
            io_out[m] <= drv[m].out;
            io_oe[m]  <= drv[m].oe & ~prog_r;
         end
      end
   end

endmodule : configurable_macrocell_array

// ===== bench/cell_array_props.sv
`timescale 1ns/100ps
module cell_array_props
   import cell_array_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [NUM_MC-1:0] io_oe
);
   // ************
   // helper state
   // ************
   logic setup;
   logic wdone;
   logic prog_r;
   logic sec_r;

   // bus phase decode
   assign setup = psel && !penable;
   assign wdone = psel && penable && pready && pwrite && !pslverr;

   // mirror of prog and protection, protection only clears on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_r <= 1'b0;
         sec_r  <= 1'b0;
      end else if (wdone && paddr == ADDR_CTRL) begin
         prog_r <= pwdata[CTRL_PROG_BIT];
         sec_r  <= sec_r | pwdata[CTRL_SECURE_BIT];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ************
   // properties
   // ************
   a_ready_next: assert property (setup |=> pready)
      else $error("no answer in access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data outside access");
   a_unmapped_err: assert property (setup && paddr > ADDR_SIG_HI |=> pslverr)
      else $error("unmapped access accepted");
   a_secure_blocks: assert property (
      sec_r && setup && (paddr == ADDR_ROW_DATA || (pwrite && paddr == ADDR_PRELOAD))
      |=> pslverr) else $error("secured access accepted");
   a_secure_zero: assert property (
      sec_r && setup && !pwrite && paddr == ADDR_ROW_DATA |=> prdata == 32'h0000_0000)
      else $error("secured pattern leaked");
   a_sig_open: assert property (
      setup && !pwrite && (paddr == ADDR_SIG_LO || paddr == ADDR_SIG_HI)
      |=> pready && !pslverr) else $error("signature read refused");
   a_prog_quiet: assert property (prog_r && $past(prog_r) |-> io_oe == '0)
      else $error("pins driven while programming");

   // main scenarios reached
   c_preload: cover property (setup && pwrite && paddr == ADDR_PRELOAD);
   c_refused: cover property (pslverr);
   c_driving: cover property (io_oe != '0);
endmodule : cell_array_props

// ===== bench/board_model.sv
`timescale 1ns/100ps
module board_model
   import cell_array_pkg::*;
(
   input  wire logic [NUM_MC-1:0] io_out,
   input  wire logic [NUM_MC-1:0] io_oe,
   input  wire logic [NUM_MC-1:0] ext_val,
   input  wire logic [NUM_MC-1:0] ext_drv,
   output logic      [NUM_MC-1:0] io_in,
   output logic      [NUM_MC-1:0] io_driven
);
   // wire level: device driver, then board driver, else weak pull-up
   always_comb begin
      for (int m = 0; m < NUM_MC; m++) begin
         io_in[m] = io_oe[m] ? io_out[m] : (ext_drv[m] ? ext_val[m] : 1'b1);
      end
   end

   // board tells the device which pins it drives
   assign io_driven = ext_drv;
endmodule : board_model

// ===== bench/tb_configurable_macrocell_array.sv
`timescale 1ns/100ps
module tb_configurable_macrocell_array
   import cell_array_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        clk_pin, clk_pin_driven, oe_pin_n, oe_pin_driven;
   logic [7:0]  paddr, in_pin, in_pin_driven, io_in, io_driven, io_out, io_oe, ext_val, ext_drv;
   logic [31:0] pwdata, prdata;
   int          err_count, check_count;

   // 20 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   configurable_macrocell_array dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_pin(in_pin), .in_pin_driven(in_pin_driven),
      .clk_pin(clk_pin), .clk_pin_driven(clk_pin_driven), .oe_pin_n(oe_pin_n),
      .oe_pin_driven(oe_pin_driven), .io_in(io_in), .io_driven(io_driven),
      .io_out(io_out), .io_oe(io_oe));

   board_model board_u (.io_out(io_out), .io_oe(io_oe), .ext_val(ext_val),
      .ext_drv(ext_drv), .io_in(io_in), .io_driven(io_driven));

   // ************
   // bus tasks
   // ************
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // request held until ready is seen, then one idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(32'(pready), 32'h0000_0001);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk(32'(e), 32'(ee));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(q, x);
      chk(32'(e), 32'(ee));
   endtask : rd

   // ************
   // scenarios
   // ************
   task automatic t_reset;
      rd(ADDR_STATUS, 32'h0000_0000, 1'b0);
      chk(32'(io_oe), 32'h0000_0000);
      rd(8'h24, 32'h0000_0000, 1'b1);
      wr(ADDR_MODE, 32'h0000_0001, 1'b1);
      $display("t_reset done");
   endtask : t_reset

   // cell 1 registered on in 0, cell 2 comb out of in 1, rest inputs
   task automatic t_regd;
      wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
      wr(ADDR_MCCFG, 32'h00db_6d06, 1'b0);
      rd(ADDR_MCCFG, 32'h00db_6d06, 1'b0);
      wr(ADDR_ROW_SEL, 32'h0000_0008, 1'b0);
      wr(ADDR_ROW_DATA, 32'h0000_0001, 1'b0);
      wr(ADDR_ROW_SEL, 32'h0000_0011, 1'b0);
      wr(ADDR_ROW_DATA, 32'h0000_0004, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0000, 1'b0);
      cyc(3);
      chk(32'(io_out[2:1]), 32'h0000_0003);
      chk(32'(io_oe), 32'h0000_0004);
      in_pin_driven <= 8'h03;
      in_pin        <= 8'h01;
      oe_pin_driven <= 1'b1;
      oe_pin_n      <= 1'b0;
      cyc(3);
      chk(32'(io_oe), 32'h0000_0006);
      chk(32'(io_out[2:1]), 32'h0000_0001);
      clk_pin <= 1'b1;
      cyc(3);
      chk(32'(io_out[2:1]), 32'h0000_0000);
      rd(ADDR_STATUS, 32'h0000_0002, 1'b0);
      clk_pin <= 1'b0;
      $display("t_regd done");
   endtask : t_regd

   // cell 3 follows the clock pin through slot 0
   task automatic t_complex;
      wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
      wr(ADDR_MODE, 32'h0000_0001, 1'b0);
      rd(ADDR_MODE, 32'h0000_0001, 1'b0);
      wr(ADDR_MCCFG, 32'h00db_65b6, 1'b0);
      wr(ADDR_ROW_SEL, 32'h0000_0019, 1'b0);
      wr(ADDR_ROW_DATA, 32'h0001_0000, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0000, 1'b0);
      for (int v = 0; v < 2; v++) begin
         clk_pin <= v[0];
         cyc(3);
         chk(32'(io_out[3]), 32'(v));
         chk(32'(io_oe[3]), 32'h0000_0001);
      end
      rd(ADDR_STATUS, 32'h0000_0002, 1'b0);
      $display("t_complex done");
   endtask : t_complex

   // centre cells always on; cell 4 sees pin 0 through slot 1, cell 3 inverted
   task automatic t_simple;
      wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
      wr(ADDR_MODE, 32'h0000_0002, 1'b0);
      wr(ADDR_MCCFG, 32'h00db_67b6, 1'b0);
      wr(ADDR_ROW_SEL, 32'h0000_0020, 1'b0);
      wr(ADDR_ROW_DATA, 32'h0004_0000, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0000, 1'b0);
      ext_drv <= 8'h01;
      for (int v = 0; v < 2; v++) begin
         clk_pin <= v[0];
         ext_val <= 8'(v);
         cyc(3);
         chk(32'(io_out[4:3]), 32'(v ? 2 : 1));
         chk(32'(io_oe[4:3]), 32'h0000_0003);
      end
      clk_pin <= 1'b0;
      $display("t_simple done");
   endtask : t_simple

   task automatic t_secure;
      wr(ADDR_PRELOAD, 32'h0000_00a5, 1'b0);
      rd(ADDR_STATUS, 32'h0000_00a5, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0001, 1'b0);
      wr(ADDR_SIG_LO, 32'h1234_5678, 1'b0);
      wr(ADDR_SIG_HI, 32'h9abc_def0, 1'b0);
      wr(ADDR_CTRL, 32'h0000_0003, 1'b0);
      wr(ADDR_PRELOAD, 32'h0000_005a, 1'b1);
      rd(ADDR_ROW_DATA, 32'h0000_0000, 1'b1);
      rd(ADDR_STATUS, 32'h0000_07a5, 1'b0);
      rd(ADDR_SIG_LO, 32'h1234_5678, 1'b0);
      rd(ADDR_SIG_HI, 32'h9abc_def0, 1'b0);
      $display("t_secure done");
   endtask : t_secure

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim

   // main sequence, reset held 10 cycles
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {in_pin, in_pin_driven, ext_val, ext_drv, clk_pin, oe_pin_driven} = '0;
      {clk_pin_driven, oe_pin_n} = 2'b11;
      err_count = 0;
      check_count = 0;
      cyc(10);
      presetn <= 1'b1;
      cyc(1);
      t_reset;
      t_regd;
      t_complex;
      t_simple;
      t_secure;
      end_sim;
   end

   // run needs about 140 cycles; margin well above that
   initial begin
      cyc(5000);
      err_count++;
      end_sim;
   end
endmodule : tb_configurable_macrocell_array

bind configurable_macrocell_array cell_array_props props_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_oe(io_oe));
